// ---- rtl/sfd_decoder.sv ----
// What this block does
// - Mode bits 00 make the word a special-function command.
// - Bits 21..16 are the function code; low sixteen bits are payload.
// - Control payload bit 4 is read-only overtemperature; writes never change it.
// - Control bit 2 picks input bank B when one, bank A when zero.
// - Control bit 1 enables thermal shutdown when one.
// - Control bit 0 requests software power-down when one, power-up when zero.
// - Code 000010 loads payload 13..0 into first offset register.
// - Code 000011 loads payload 13..0 into second offset register.
// - Codes 000110..001001 load low payload byte into bank-select registers 0..3.
// - Code 001011 writes the low byte into all four bank-select registers.
// - Code 000101 latches the payload as the readback selection.
// - Payload starting with one selects a single register by upper nine bits.
// - Payload bits 6..0 are ignored when decoding a readback selection.
// - Selected register shifts out on the serial output in the next transfer.
// - Data writes go to bank A when control bank bit zero, else B.
`timescale 1ns/10ps
`include "sfd_regs.svh"

module sfd_decoder
   import sfd_pkg::*;
#(
   parameter int WORD_W = `SFD_WORD_W
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // serial pins
   input  wire logic        sclk_i,
   input  wire logic        sync_n_i,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   output logic             sdo_oe_n_o,
   // status pin
   input  wire logic        overtemp_i,
   // channel readback data, same clock
   input  wire logic [15:0] chan_rd_data_i,
   // control register fields
   output logic             ctrl_bank_b_o,
   output logic             thermal_sd_en_o,
   output logic             soft_pd_o,
   // offset registers
   output logic [13:0]      offset_dac_zero_o,
   output logic [13:0]      offset_dac_one_o,
   // bank-select registers, register n in bits 8n+7..8n
   output logic [31:0]      bank_select_o,
   // readback selection
   output logic [15:0]      rb_sel_o,
   // channel data write request
   output logic             data_wr_valid_o,
   output logic [1:0]       data_wr_mode_o,
   output logic [5:0]       data_wr_addr_o,
   output logic [15:0]      data_wr_data_o,
   output logic             data_wr_bank_b_o
);

   // ==========================================
   // pin synchronisers
   logic [3:0] sync1_q;
   logic [3:0] sync1_d;
   logic [3:0] sync2_q;
   logic [3:0] sync2_d;
   logic [2:0] prev_q;
   logic [2:0] prev_d;
   logic       sclk_s;
   logic       sync_n_s;
   logic       sdi_s;
   logic       ot_s;
   logic       sclk_fall;
   logic       sync_fall;
   logic       sync_rise;

   always_comb begin
      sync1_d = {overtemp_i, sdi_i, sync_n_i, sclk_i};
      sync2_d = sync1_q;
      prev_d  = sync2_q[2:0];
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 4'h3;
         sync2_q <= 4'h3;
         prev_q  <= 3'h3;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
      end
   end

   assign sclk_s    = sync2_q[0];
   assign sync_n_s  = sync2_q[1];
   assign sdi_s     = sync2_q[2];
   assign ot_s      = sync2_q[3];
   // data sampled on the falling serial clock edge
   assign sclk_fall = prev_q[0] & ~sclk_s;
   assign sync_fall = prev_q[1] & ~sync_n_s;
   assign sync_rise = ~prev_q[1] & sync_n_s;

   // ==========================================
   // frame receiver
   sfd_frame_t        frame_q;
   sfd_frame_t        frame_d;
   logic [4:0]        cnt_q;
   logic [4:0]        cnt_d;
   logic [WORD_W-1:0] sh_q;
   logic [WORD_W-1:0] sh_d;
   logic              word_vld_q;
   logic              word_vld_d;
   logic              shift_q;
   logic              shift_d;
   logic              end_q;
   logic              end_d;

   always_comb begin
      frame_d    = frame_q;
      cnt_d      = cnt_q;
      sh_d       = sh_q;
      word_vld_d = 1'b0;
      shift_d    = 1'b0;
      end_d      = 1'b0;
      case (frame_q)
         SFD_FR_IDLE: begin
            if (sync_fall) begin
               frame_d = SFD_FR_ACTIVE;
               cnt_d   = '0;
            end
         end
         SFD_FR_ACTIVE: begin
            if (sync_rise) begin
               frame_d = SFD_FR_IDLE;
               end_d   = 1'b1;
               // short or long frames are dropped whole
               word_vld_d = (cnt_q == `SFD_WORD_BITS);
            end else if (sclk_fall) begin
               sh_d    = {sh_q[WORD_W-2:0], sdi_s};
               shift_d = 1'b1;
               if (cnt_q != `SFD_CNT_MAX) begin
                  cnt_d = cnt_q + 5'h01;
               end
            end
         end
         default: frame_d = SFD_FR_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_q    <= SFD_FR_IDLE;
         cnt_q      <= '0;
         sh_q       <= '0;
         word_vld_q <= 1'b0;
         shift_q    <= 1'b0;
         end_q      <= 1'b0;
      end else begin
         frame_q    <= frame_d;
         cnt_q      <= cnt_d;
         sh_q       <= sh_d;
         word_vld_q <= word_vld_d;
         shift_q    <= shift_d;
         end_q      <= end_d;
      end
   end

   // ==========================================
   // word fields
   logic [1:0]  mode;
   logic [5:0]  fn;
   logic [15:0] pl;
   logic        spec;

   assign mode = sh_q[`SFD_MODE_HI:`SFD_MODE_LO];
   assign fn   = sh_q[`SFD_FN_MSB:`SFD_FN_LSB];
   assign pl   = sh_q[`SFD_PL_MSB:`SFD_PL_LSB];
   assign spec = word_vld_q && (mode == `SFD_MODE_SPEC);

   // ==========================================
   // register file
   logic [2:0]  ctrl_q;
   logic [2:0]  ctrl_d;
   logic [13:0] offset_dac_zero_q;
   logic [13:0] offset_dac_zero_d;
   logic [13:0] offset_dac_one_q;
   logic [13:0] offset_dac_one_d;
   sfd_ab_t     ab_q;
   sfd_ab_t     ab_d;
   logic [15:0] rbsel_q;
   logic [15:0] rbsel_d;
   logic        rb_pend_q;
   logic        rb_pend_d;
   logic        wr_vld_q;
   logic        wr_vld_d;
   logic [1:0]  wr_mode_q;
   logic [1:0]  wr_mode_d;
   logic [5:0]  wr_addr_q;
   logic [5:0]  wr_addr_d;
   logic [15:0] wr_data_q;
   logic [15:0] wr_data_d;
   logic        wr_bank_q;
   logic        wr_bank_d;

   always_comb begin
      ctrl_d    = ctrl_q;
      offset_dac_zero_d    = offset_dac_zero_q;
      offset_dac_one_d    = offset_dac_one_q;
      ab_d      = ab_q;
      rbsel_d   = rbsel_q;
      rb_pend_d = 1'b0;
      wr_vld_d  = 1'b0;
      wr_mode_d = wr_mode_q;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      wr_bank_d = wr_bank_q;
      if (spec) begin
         case (fn)
            `SFD_FN_CTRL: begin
               // bits 4 and 3 are not stored, so writes cannot touch them
               ctrl_d = pl[`SFD_CTL_BANK:`SFD_CTL_PD];
            end
            `SFD_FN_OFFSET_DAC_ZERO:  offset_dac_zero_d = pl[`SFD_OFS_MSB:0];
            `SFD_FN_OFFSET_DAC_ONE:  offset_dac_one_d = pl[`SFD_OFS_MSB:0];
            `SFD_FN_AB0:   ab_d[0] = pl[`SFD_AB_MSB:0];
            `SFD_FN_AB1:   ab_d[1] = pl[`SFD_AB_MSB:0];
            `SFD_FN_AB2:   ab_d[2] = pl[`SFD_AB_MSB:0];
            `SFD_FN_AB3:   ab_d[3] = pl[`SFD_AB_MSB:0];
            `SFD_FN_ABALL: ab_d = {4{pl[`SFD_AB_MSB:0]}};
            `SFD_FN_RBSEL: begin
               rbsel_d   = pl;
               rb_pend_d = 1'b1;
            end
            default: ;
         endcase
      end else if (word_vld_q) begin
         wr_vld_d  = 1'b1;
         wr_mode_d = mode;
         wr_addr_d = fn;
         wr_data_d = pl;
         wr_bank_d = ctrl_q[`SFD_CTL_BANK];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q    <= `SFD_CTRL_RST;
         offset_dac_zero_q    <= `SFD_OFS_RST;
         offset_dac_one_q    <= `SFD_OFS_RST;
         ab_q      <= {4{`SFD_AB_RST}};
         rbsel_q   <= `SFD_RBSEL_RST;
         rb_pend_q <= 1'b0;
         wr_vld_q  <= 1'b0;
         wr_mode_q <= '0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_bank_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         offset_dac_zero_q    <= offset_dac_zero_d;
         offset_dac_one_q    <= offset_dac_one_d;
         ab_q      <= ab_d;
         rbsel_q   <= rbsel_d;
         rb_pend_q <= rb_pend_d;
         wr_vld_q  <= wr_vld_d;
         wr_mode_q <= wr_mode_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         wr_bank_q <= wr_bank_d;
      end
   end

   // ==========================================
   // readback source
   // channel data is fetched one cycle after the selection
   // is latched, so the outside has rb_sel_o settled
   function automatic logic [15:0] rb_value(
      input logic [15:0] sel,
      input logic [4:0]  ctl,
      input logic [13:0] o0,
      input logic [13:0] o1,
      input sfd_ab_t     ab,
      input logic [15:0] chan
   );
      logic [15:0] v;
      v = '0;
      if (!sel[`SFD_RB_KEY_MSB]) begin
         v = chan;
      end else begin
         case (sel[`SFD_RB_KEY_MSB:`SFD_RB_KEY_LSB])
            `SFD_RB_CTRL: v = {11'h000, ctl};
            `SFD_RB_OFFSET_DAC_ZERO: v = {2'h0, o0};
            `SFD_RB_OFFSET_DAC_ONE: v = {2'h0, o1};
            `SFD_RB_AB0:  v = {8'h00, ab[0]};
            `SFD_RB_AB1:  v = {8'h00, ab[1]};
            `SFD_RB_AB2:  v = {8'h00, ab[2]};
            `SFD_RB_AB3:  v = {8'h00, ab[3]};
            default:      v = '0;
         endcase
      end
      return v;
   endfunction : rb_value

   logic [4:0] ctrl_rd;
   // overtemperature comes from the pin, bit 3 reads zero
   assign ctrl_rd = {ot_s, 1'b0, ctrl_q};

   // ==========================================
   // readback shifter
   sfd_rb_if #(.WORD_W(WORD_W)) rb ();

   assign rb.load      = rb_pend_q;
   assign rb.word      = {8'h00, rb_value(rbsel_q, ctrl_rd, offset_dac_zero_q,
                                          offset_dac_one_q, ab_q, chan_rd_data_i)};
   assign rb.shift     = shift_q;
   assign rb.frame_end = end_q;

   sfd_rb_shifter #(.WORD_W(WORD_W)) u_shifter (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .rb      (rb.shifter)
   );

   // ==========================================
   // outputs
   assign sdo_o             = rb.serial_out_pin;
   assign sdo_oe_n_o        = rb.sdo_oe_n;
   assign ctrl_bank_b_o     = ctrl_q[`SFD_CTL_BANK];
   assign thermal_sd_en_o   = ctrl_q[`SFD_CTL_TSD];
   assign soft_pd_o         = ctrl_q[`SFD_CTL_PD];
   assign offset_dac_zero_o = offset_dac_zero_q;
   assign offset_dac_one_o  = offset_dac_one_q;
   assign bank_select_o     = ab_q;
   assign rb_sel_o          = rbsel_q;
   assign data_wr_valid_o   = wr_vld_q;
   assign data_wr_mode_o    = wr_mode_q;
   assign data_wr_addr_o    = wr_addr_q;
   assign data_wr_data_o    = wr_data_q;
   assign data_wr_bank_b_o  = wr_bank_q;

endmodule : sfd_decoder

// ---- rtl/sfd_rb_shifter.sv ----
`timescale 1ns/10ps

module sfd_rb_shifter #(
   parameter int WORD_W = 24
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // readback link
   sfd_rb_if.shifter rb
);

   logic [WORD_W-1:0] sh_q;
   logic [WORD_W-1:0] sh_d;
   logic              oe_n_q;
   logic              oe_n_d;
   logic              used_q;
   logic              used_d;

   // ==========================================
   // readback shift register
   // pin is driven from the load onward, then released at
   // the end of the frame that clocked the data out
   always_comb begin
      sh_d   = sh_q;
      oe_n_d = oe_n_q;
      used_d = used_q;
      if (rb.load) begin
         sh_d   = rb.word;
         oe_n_d = 1'b0;
         used_d = 1'b0;
      end else if (rb.shift && !oe_n_q) begin
         sh_d   = {sh_q[WORD_W-2:0], 1'b0};
         used_d = 1'b1;
      end else if (rb.frame_end && used_q) begin
         oe_n_d = 1'b1;
         used_d = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q   <= '0;
         oe_n_q <= 1'b1;
         used_q <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         oe_n_q <= oe_n_d;
         used_q <= used_d;
      end
   end

   assign rb.serial_out_pin      = sh_q[WORD_W-1];
   assign rb.sdo_oe_n = oe_n_q;

endmodule : sfd_rb_shifter

// ---- shared/sfd_pkg.sv ----
`include "sfd_regs.svh"

package sfd_pkg;

   // ==========================================
   // types
   typedef enum logic [0:0] {
      SFD_FR_IDLE   = 1'b0,
      SFD_FR_ACTIVE = 1'b1
   } sfd_frame_t;

   typedef logic [3:0][7:0] sfd_ab_t;

endpackage : sfd_pkg

// ---- shared/sfd_rb_if.sv ----
`timescale 1ns/10ps

interface sfd_rb_if #(parameter int WORD_W = 24);
   logic              load;
   logic [WORD_W-1:0] word;
   logic              shift;
   logic              frame_end;
   logic              serial_out_pin;
   logic              sdo_oe_n;

   modport ctrl (
      output load,
      output word,
      output shift,
      output frame_end,
      input  serial_out_pin,
      input  sdo_oe_n
   );

   modport shifter (
      input  load,
      input  word,
      input  shift,
      input  frame_end,
      output serial_out_pin,
      output sdo_oe_n
   );
endinterface : sfd_rb_if

// ---- shared/sfd_regs.svh ----
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// ==========================================
// serial word layout
`define SFD_WORD_W    24
`define SFD_WORD_BITS 5'h18
`define SFD_CNT_MAX   5'h1F
`define SFD_MODE_HI   23
`define SFD_MODE_LO   22
`define SFD_FN_MSB    21
`define SFD_FN_LSB    16
`define SFD_PL_MSB    15
`define SFD_PL_LSB    0
`define SFD_MODE_SPEC 2'h0

// ==========================================
// function codes
`define SFD_FN_NOP    6'h00
`define SFD_FN_CTRL   6'h01
`define SFD_FN_OFFSET_DAC_ZERO   6'h02
`define SFD_FN_OFFSET_DAC_ONE   6'h03
`define SFD_FN_RSV4   6'h04
`define SFD_FN_RBSEL  6'h05
`define SFD_FN_AB0    6'h06
`define SFD_FN_AB1    6'h07
`define SFD_FN_AB2    6'h08
`define SFD_FN_AB3    6'h09
`define SFD_FN_RSVA   6'h0A
`define SFD_FN_ABALL  6'h0B

// ==========================================
// control payload bits
`define SFD_CTL_OT    4
`define SFD_CTL_BANK  2
`define SFD_CTL_TSD   1
`define SFD_CTL_PD    0

// ==========================================
// payload field widths
`define SFD_OFS_MSB   13
`define SFD_AB_MSB    7

// ==========================================
// readback selection, payload bits 15..7
`define SFD_RB_KEY_MSB 15
`define SFD_RB_KEY_LSB 7
`define SFD_RB_CTRL   9'h101
`define SFD_RB_OFFSET_DAC_ZERO   9'h102
`define SFD_RB_OFFSET_DAC_ONE   9'h103
`define SFD_RB_AB0    9'h106
`define SFD_RB_AB1    9'h107
`define SFD_RB_AB2    9'h108
`define SFD_RB_AB3    9'h109

// ==========================================
// reset values
`define SFD_CTRL_RST  3'h0
`define SFD_OFS_RST   14'h0000
`define SFD_AB_RST    8'h00
`define SFD_RBSEL_RST 16'h0000

`endif

// ---- testbench/sfd_decoder_props.sv ----
`timescale 1ns/10ps

module sfd_decoder_props (
   // clock and reset
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   // frame pin and readback enable
   input wire logic        sync_n_i,
   input wire logic        sdo_oe_n_o,
   // registers
   input wire logic        ctrl_bank_b_o,
   input wire logic        thermal_sd_en_o,
   input wire logic        soft_pd_o,
   input wire logic [13:0] offset_dac_zero_o,
   input wire logic [13:0] offset_dac_one_o,
   input wire logic [31:0] bank_select_o,
   input wire logic [15:0] rb_sel_o,
   // data write port
   input wire logic        data_wr_valid_o,
   input wire logic [1:0]  data_wr_mode_o,
   input wire logic [5:0]  data_wr_addr_o,
   input wire logic [15:0] data_wr_data_o,
   input wire logic        data_wr_bank_b_o
);
   // ==========================================
   // register updates only land between frames
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   valid_pulse_a : assert property (
      data_wr_valid_o |=> !data_wr_valid_o) else $error("write strobe too long");
   valid_mode_a : assert property (
      data_wr_valid_o |-> data_wr_mode_o != 2'h0) else $error("write strobe on mode 00");
   bank_follow_a : assert property (
      data_wr_valid_o |-> data_wr_bank_b_o == ctrl_bank_b_o) else $error("wrong bank");
   data_held_a : assert property (
      $changed({data_wr_mode_o, data_wr_addr_o, data_wr_data_o}) |-> data_wr_valid_o)
      else $error("write fields moved without strobe");
   ctrl_when_a : assert property (
      $changed({ctrl_bank_b_o, thermal_sd_en_o, soft_pd_o}) |-> sync_n_i && !data_wr_valid_o)
      else $error("control changed out of turn");
   ofs_when_a : assert property (
      $changed({offset_dac_zero_o, offset_dac_one_o}) |-> sync_n_i && !data_wr_valid_o)
      else $error("offset changed out of turn");
   ab_when_a : assert property (
      $changed(bank_select_o) |-> sync_n_i && !data_wr_valid_o)
      else $error("bank select changed out of turn");
   rbsel_alone_a : assert property (
      $changed(rb_sel_o) |-> sync_n_i && $stable(bank_select_o) && $stable(offset_dac_zero_o))
      else $error("selection changed with other register");
   oe_start_a : assert property (
      $fell(sdo_oe_n_o) |-> sync_n_i) else $error("output driven inside a frame");
   oe_hold_a : assert property (
      !sdo_oe_n_o && !sync_n_i |=> !sdo_oe_n_o) else $error("output released mid frame");
endmodule : sfd_decoder_props

bind sfd_decoder sfd_decoder_props u_props (
   .clock_i, .rst_n_i, .sync_n_i, .sdo_oe_n_o, .ctrl_bank_b_o, .thermal_sd_en_o,
   .soft_pd_o, .offset_dac_zero_o, .offset_dac_one_o, .bank_select_o, .rb_sel_o,
   .data_wr_valid_o, .data_wr_mode_o, .data_wr_addr_o, .data_wr_data_o, .data_wr_bank_b_o
);

// ---- testbench/sfd_host_model.sv ----
`timescale 1ns/10ps
`include "sfd_regs.svh"

module sfd_host_model (
   // clock
   input  wire logic clock_i,
   // serial pins
   output logic      sclk_o,
   output logic      sync_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   // ==========================================
   // clock idles high, four cycles per phase
   initial begin
      sclk_o   = 1'b1;
      sync_n_o = 1'b1;
      sdi_o    = 1'b0;
   end

   task automatic frame(input logic [23:0] w, input logic raw, output logic [23:0] r);
      logic [23:0] v;
      v = w;
      if (!raw && w[23:16] == {2'b00, `SFD_FN_CTRL}) v[4:3] = 2'b00;
      @(negedge clock_i);
      sync_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi_o = v[i];
         repeat (4) @(negedge clock_i);
         // sampled at end of high phase, where the falling edge left it
         r[i] = sdo_i;
         sclk_o = 1'b0;
         repeat (4) @(negedge clock_i);
         sclk_o = 1'b1;
      end
      repeat (4) @(negedge clock_i);
      sync_n_o = 1'b1;
      // released data line shows the inverse, not a stale value
      sdi_o = ~sdi_o;
      repeat (8) @(negedge clock_i);
   endtask : frame

   // only the first n bits of w; the decoder must drop such a word whole
   task automatic cut_frame(input logic [23:0] w, input int n);
      @(negedge clock_i);
      sync_n_o = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         sdi_o = w[i];
         repeat (4) @(negedge clock_i);
         sclk_o = 1'b0;
         repeat (4) @(negedge clock_i);
         sclk_o = 1'b1;
      end
      repeat (4) @(negedge clock_i);
      sync_n_o = 1'b1;
      sdi_o = ~sdi_o;
      repeat (8) @(negedge clock_i);
   endtask : cut_frame
endmodule : sfd_host_model

// ---- testbench/tb_sfd_decoder.sv ----
`timescale 1ns/10ps
`include "sfd_regs.svh"

module tb_sfd_decoder;
   logic        clock_i, rst_n_i, sclk, sync_n, sdi, serial_out_pin, oe_n, ot, bank_b, tsd, pd, wv, wb;
   logic [15:0] chan, rbs, wd;
   logic [13:0] offset_dac_zero, offset_dac_one;
   logic [31:0] absel;
   logic [1:0]  wm;
   logic [5:0]  wa;
   logic [23:0] r;
   int          mismatches, n_checks, pulses;

   // released output pin shows the inverse of its last bit, so early release shows up
   sfd_host_model u_host (.clock_i(clock_i), .sclk_o(sclk), .sync_n_o(sync_n),
      .sdi_o(sdi), .sdo_i(oe_n ? ~serial_out_pin : serial_out_pin));
   sfd_decoder u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .sync_n_i(sync_n),
      .sdi_i(sdi), .sdo_o(serial_out_pin), .sdo_oe_n_o(oe_n), .overtemp_i(ot), .chan_rd_data_i(chan),
      .ctrl_bank_b_o(bank_b), .thermal_sd_en_o(tsd), .soft_pd_o(pd), .offset_dac_zero_o(offset_dac_zero),
      .offset_dac_one_o(offset_dac_one), .bank_select_o(absel), .rb_sel_o(rbs), .data_wr_valid_o(wv),
      .data_wr_mode_o(wm), .data_wr_addr_o(wa), .data_wr_data_o(wd), .data_wr_bank_b_o(wb));

   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end

   always @(negedge clock_i) if (wv === 1'b1) pulses++;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [5:0] code, input logic [15:0] pl);
      u_host.frame({2'b00, code, pl}, 1'b0, r);
   endtask : wr

   // command frame, then a no-op frame to clock the answer out
   task rd(input logic [15:0] pl);
      u_host.frame({2'b00, `SFD_FN_RBSEL, pl}, 1'b0, r);
      chk(oe_n, 32'h0);
      u_host.frame(24'h000000, 1'b0, r);
      chk(oe_n, 32'h1);
   endtask : rd

   task t_reset;
      chk({offset_dac_zero, offset_dac_one}, 32'h0);
      chk(absel, 32'h0);
      chk(rbs, 32'h0);
      chk({oe_n, bank_b, tsd, pd, wv}, 32'h10);
      $display("t_reset done");
   endtask : t_reset

   task t_ctrl;
      ot = 1'b1;
      u_host.frame({2'b00, `SFD_FN_CTRL, 16'h001F}, 1'b1, r);
      chk({bank_b, tsd, pd}, 32'h7);
      rd(16'h80FF);
      chk(r, 32'h000017);
      ot = 1'b0;
      wr(`SFD_FN_CTRL, 16'hFFE2);
      chk({bank_b, tsd, pd}, 32'h2);
      rd(16'h8080);
      chk(r, 32'h000002);
      $display("t_ctrl done");
   endtask : t_ctrl

   task t_ofs;
      wr(`SFD_FN_OFFSET_DAC_ZERO, 16'hC123);
      wr(`SFD_FN_OFFSET_DAC_ONE, 16'hBEEF);
      chk(offset_dac_zero, 32'h0123);
      chk(offset_dac_one, 32'h3EEF);
      rd(16'h8100);
      chk(r, 32'h000123);
      rd(16'h81FF);
      chk(r, 32'h003EEF);
      $display("t_ofs done");
   endtask : t_ofs

   task t_ab;
      wr(`SFD_FN_AB0, 16'hFF11);
      wr(`SFD_FN_AB1, 16'hAA22);
      wr(`SFD_FN_AB2, 16'h0033);
      wr(`SFD_FN_AB3, 16'h5544);
      chk(absel, 32'h44332211);
      rd(16'h8400);
      chk(r, 32'h000033);
      wr(`SFD_FN_ABALL, 16'h12FF);
      chk(absel, 32'hFFFFFFFF);
      wr(`SFD_FN_ABALL, 16'h3400);
      chk(absel, 32'h0);
      $display("t_ab done");
   endtask : t_ab

   task t_nop;
      logic [5:0] codes [5];
      codes = '{6'h00, 6'h04, 6'h0A, 6'h0C, 6'h3F};
      rd(16'h8200);
      chk(r, 32'h0);
      // 23 bits that would read as an offset write if the count were ignored
      u_host.cut_frame(24'h043FFE, 23);
      chk(offset_dac_zero, 32'h0123);
      foreach (codes[i]) begin
         wr(codes[i], 16'hFFFF);
         chk({offset_dac_zero, offset_dac_one, bank_b, tsd, pd}, {14'h0123, 14'h3EEF, 3'h2});
         chk(absel, 32'h0);
         chk(rbs, 32'h8200);
      end
      $display("t_nop done");
   endtask : t_nop

   task t_data;
      pulses = 0;
      wr(`SFD_FN_CTRL, 16'h0004);
      u_host.frame({2'b11, 6'h2A, 16'hBEEF}, 1'b0, r);
      chk({wm, wa, wd, wb}, {2'h3, 6'h2A, 16'hBEEF, 1'b1});
      wr(`SFD_FN_CTRL, 16'h0000);
      u_host.frame({2'b01, 6'h05, 16'h1357}, 1'b0, r);
      chk({wm, wa, wd, wb}, {2'h1, 6'h05, 16'h1357, 1'b0});
      chk({offset_dac_zero, absel[7:0]}, {14'h0123, 8'h00});
      chk(pulses, 32'h2);
      $display("t_data done");
   endtask : t_data

   task t_chan;
      chan = 16'hA5C3;
      rd(16'h33D5);
      chk(r, 32'h00A5C3);
      chk(rbs, 32'h33D5);
      $display("t_chan done");
   endtask : t_chan

   // reset while the readback output is driven
   task t_rst_mid;
      u_host.frame({2'b00, `SFD_FN_RBSEL, 16'h8100}, 1'b0, r);
      chk(oe_n, 32'h0);
      rst_n_i = 1'b0;
      repeat (3) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clock_i);
      chk({oe_n, offset_dac_zero}, 32'h4000);
      chk({rbs, absel[7:0]}, 32'h0);
      $display("t_rst_mid done");
   endtask : t_rst_mid

   task test_done;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   initial begin
      #3000000;
      mismatches++;
      test_done();
   end

   initial begin
      rst_n_i = 1'b0;
      ot      = 1'b0;
      chan    = 16'h0000;
      repeat (3) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (5) @(negedge clock_i);
      t_reset();
      t_ctrl();
      t_ofs();
      t_ab();
      t_nop();
      t_data();
      t_chan();
      t_rst_mid();
      test_done();
   end
endmodule : tb_sfd_decoder
